// *** rmcr_regs.sv ***
// runtime misc control register bank, top
`include "rmcr_map.svh"
`default_nettype none
module rmcr_regs #(
    parameter int POWER_OK_DELAY_CYC = `RMCR_POWER_OK_DELAY_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic vccResetN,
    input wire logic standbyPorN,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic serialBFifoWrite,
    input wire logic [7:0] serialBFifoData,
    input wire logic floppyValid,
    input wire logic serialAValid,
    input wire logic serialBValid,
    input wire logic parallelValid,
    output logic floppyAccessOn,
    output logic serialAAccessOn,
    output logic serialBAccessOn,
    output logic parallelAccessOn,
    input wire logic drive_select_a_n,
    input wire logic drive_select_b_n,
    input wire logic forceProtect,
    input wire logic write_protect_n,
    output logic coreWriteProtect,
    input wire logic sleep_s3_n,
    input wire logic sleep_s5_n,
    input wire logic supply_good_in,
    output logic ledLevel,
    output logic ledColor,
    output logic [7:0] wakeKeyCode,
    output logic power_ok_out,
    input wire logic lpcResetN,
    output logic [3:0] bufferedResetN,
    output logic [5:0] pinSelect
);
    logic [7:0] fifoShadow;
    logic [7:0] devDisable;
    logic [3:0] ledReg;
    logic [7:0] powerGood;
    logic inS0;
    logic ledWritable;
    rmcr_pkg::rmcr_power_type powerState;
    rmcr_pkg::rmcr_power_type lastPowerState;
    rmcr_pkg::rmcr_blink_type next_blink;
    rmcr_led_if ledBus();

    // ======================================
    // write decode
    logic wrDev, wrLed, wrKey, wrPg, wrSel;
    always_comb begin
        wrDev = 1'b0;
        wrLed = 1'b0;
        wrKey = 1'b0;
        wrPg = 1'b0;
        wrSel = 1'b0;
        // writes to 23h fall through: that offset is read only
        if (!regWrite) begin
            wrSel = 1'b0;
        end else if (regAddr == `RMCR_OFF_DEV_DISABLE) begin
            wrDev = 1'b1;
        end else if (regAddr == `RMCR_OFF_LED) begin
            wrLed = 1'b1;
        end else if (regAddr == `RMCR_OFF_WAKE_KEY) begin
            wrKey = 1'b1;
        end else if (regAddr == `RMCR_OFF_POWER_GOOD) begin
            wrPg = 1'b1;
        end else if (regAddr == `RMCR_OFF_PIN_SELECT) begin
            wrSel = 1'b1;
        end
    end

    // ======================================
    // serial fifo control shadow; host writes to 23h are ignored
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            fifoShadow <= `RMCR_RST_FIFO_SHADOW;
        end else if (serialBFifoWrite) begin
            fifoShadow <= serialBFifoData & `RMCR_MASK_FIFO_SHADOW;
        end
    end

    // ======================================
    // device disable
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            devDisable <= `RMCR_RST_DEV_DISABLE;
        end else if (wrDev) begin
            devDisable <= regWrData & `RMCR_MASK_DEV_DISABLE;
        end
    end

    // disable overrides each base address valid bit
    assign floppyAccessOn = floppyValid & ~devDisable[`RMCR_BIT_FLOPPY_BLOCK];
    assign serialBAccessOn = serialBValid & ~devDisable[`RMCR_BIT_SERIAL_B_BLOCK];
    assign serialAAccessOn = serialAValid & ~devDisable[`RMCR_BIT_SERIAL_A_BLOCK];
    assign parallelAccessOn = parallelValid & ~devDisable[`RMCR_BIT_PARALLEL_BLOCK];

    // ======================================
    // floppy write protect, active high toward the core
    logic floppy_protect_override;
    assign floppy_protect_override = devDisable[`RMCR_BIT_FWP];
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            coreWriteProtect <= 1'b0;
        end else begin
            coreWriteProtect <= (~drive_select_a_n & forceProtect)
                | (~drive_select_b_n & forceProtect)
                | ~write_protect_n
                | floppy_protect_override;
        end
    end

    // ======================================
    // power state from sleep and supply inputs
    always_comb begin
        if (!supply_good_in) begin
            powerState = rmcr_pkg::PWR_NOSUPPLY;
        end else if (!sleep_s5_n) begin
            powerState = rmcr_pkg::PWR_S5;
        end else if (!sleep_s3_n) begin
            powerState = rmcr_pkg::PWR_S3;
        end else begin
            powerState = rmcr_pkg::PWR_S0;
        end
    end
    assign inS0 = (powerState == rmcr_pkg::PWR_S0);
    assign ledWritable = inS0 || (ledReg[1:0] == rmcr_pkg::BLINK_OFF);

    // own logic picks a blink code on each power state change
    always_comb begin
        case (powerState)
            rmcr_pkg::PWR_S0: next_blink = rmcr_pkg::BLINK_ON;
            rmcr_pkg::PWR_S3: next_blink = rmcr_pkg::BLINK_SLOW;
            default: next_blink = rmcr_pkg::BLINK_OFF;
        endcase
    end

    // ======================================
    // led register; hardware change wins over a same cycle host write
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ledReg <= 4'(`RMCR_RST_LED);
            lastPowerState <= rmcr_pkg::PWR_NOSUPPLY;
        end else begin
            lastPowerState <= powerState;
            if (!vccResetN) begin
                ledReg[`RMCR_BIT_CODE_FETCH] <= 1'b0;
            end else if (wrLed && ledWritable) begin
                ledReg[3:2] <= regWrData[3:2];
            end
            if (powerState != lastPowerState) begin
                ledReg[1:0] <= next_blink;
            end else if (wrLed && ledWritable) begin
                ledReg[1:0] <= regWrData[1:0];
            end
        end
    end
    assign ledBus.blinkCode = rmcr_pkg::rmcr_blink_type'(ledReg[1:0]);
    assign ledLevel = ledBus.ledLevel;
    assign ledColor = ledReg[`RMCR_BIT_COLOR];

    rmcr_led_blink rmcr_led_blink_i (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .led(ledBus.drive)
    );

    // ======================================
    // wake key code
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wakeKeyCode <= `RMCR_RST_WAKE_KEY;
        end else if (wrKey) begin
            wakeKeyCode <= regWrData;
        end
    end

    // ======================================
    // power good; delay select and lock bits 1:0 survive system reset, reloaded only by standby por
    logic [1:0] pgStandby;
    logic [3:0] pgResetOn;
    always_ff @(posedge ref_clk) begin
        if (!standbyPorN) begin
            pgStandby <= 2'(`RMCR_RST_POWER_GOOD);
        end else if (wrPg && !pgStandby[`RMCR_BIT_LOCK]) begin
            pgStandby <= regWrData[1:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pgResetOn <= 4'(`RMCR_RST_POWER_GOOD >> 4);
        end else if (wrPg) begin
            pgResetOn <= regWrData[7:4];
        end
    end
    // bits 3:2 reserved, never stored
    assign powerGood = {pgResetOn, 2'b00, pgStandby};

    rmcr_power_good #(
        .DELAY_CYC(POWER_OK_DELAY_CYC)
    ) rmcr_power_good_i (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .delaySel(powerGood[`RMCR_BIT_DELAY_SEL]),
        .supplyGood(supply_good_in),
        .powerOk(power_ok_out)
    );

    // buffered reset outputs, forced low when disabled
    // enable bit order is not the output order
    localparam int RST_ON_BIT [4] = '{`RMCR_BIT_RST1_ON, `RMCR_BIT_RST2_ON,
        `RMCR_BIT_RST3_ON, `RMCR_BIT_RST4_ON};
    wire logic [3:0] next_bufferedResetN;
    for (genvar i = 0; i < 4; i++) begin : g_reset_out
        assign next_bufferedResetN[i] = lpcResetN & powerGood[RST_ON_BIT[i]];
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            bufferedResetN <= 4'h0;
        end else begin
            bufferedResetN <= next_bufferedResetN;
        end
    end

    // ======================================
    // pin selector
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pinSelect <= `RMCR_RST_PIN_SELECT;
        end else if (wrSel) begin
            pinSelect <= regWrData[5:0];
        end
    end

    // ======================================
    // read mux, registered; unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            regRdData <= 8'h00;
        end else if (!regRead) begin
            regRdData <= regRdData;
        end else if (regAddr == `RMCR_OFF_FIFO_SHADOW) begin
            regRdData <= fifoShadow;
        end else if (regAddr == `RMCR_OFF_DEV_DISABLE) begin
            regRdData <= devDisable;
        end else if (regAddr == `RMCR_OFF_LED) begin
            regRdData <= {4'h0, ledReg};
        end else if (regAddr == `RMCR_OFF_WAKE_KEY) begin
            regRdData <= wakeKeyCode;
        end else if (regAddr == `RMCR_OFF_POWER_GOOD) begin
            regRdData <= powerGood & `RMCR_MASK_POWER_GOOD;
        end else if (regAddr == `RMCR_OFF_PIN_SELECT) begin
            regRdData <= {2'b00, pinSelect};
        end else begin
            regRdData <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// *** rmcr_map.svh ***
// offsets, field positions and reset values of the runtime control bank
`ifndef RMCR_MAP_SVH
`define RMCR_MAP_SVH
`define RMCR_OFF_FIFO_SHADOW 8'h23
`define RMCR_OFF_DEV_DISABLE 8'h24
`define RMCR_OFF_LED 8'h25
`define RMCR_OFF_WAKE_KEY 8'h26
`define RMCR_OFF_POWER_GOOD 8'h27
`define RMCR_OFF_PIN_SELECT 8'h28
`define RMCR_RST_DEV_DISABLE 8'h00
`define RMCR_RST_LED 8'h00
`define RMCR_RST_WAKE_KEY 8'h00
`define RMCR_RST_POWER_GOOD 8'hf1
`define RMCR_RST_PIN_SELECT 6'h00
`define RMCR_RST_FIFO_SHADOW 8'h00
`define RMCR_MASK_FIFO_SHADOW 8'hcf
`define RMCR_MASK_DEV_DISABLE 8'he9
`define RMCR_MASK_LED 8'h0f
`define RMCR_MASK_POWER_GOOD 8'hf3
`define RMCR_BIT_FWP 0
`define RMCR_BIT_FLOPPY_BLOCK 3
`define RMCR_BIT_SERIAL_B_BLOCK 5
`define RMCR_BIT_SERIAL_A_BLOCK 6
`define RMCR_BIT_PARALLEL_BLOCK 7
`define RMCR_BIT_CODE_FETCH 3
`define RMCR_BIT_COLOR 2
`define RMCR_BIT_DELAY_SEL 0
`define RMCR_BIT_LOCK 1
`define RMCR_BIT_RST1_ON 6
`define RMCR_BIT_RST2_ON 7
`define RMCR_BIT_RST3_ON 5
`define RMCR_BIT_RST4_ON 4
`define RMCR_CLK_HZ 125000000
`define RMCR_HALF_BLINK_MS 500
`define RMCR_HALF_BLINK_CYC ((`RMCR_CLK_HZ / 1000) * `RMCR_HALF_BLINK_MS)
`define RMCR_POWER_OK_DELAY_CYC 1000
`endif

// *** rmcr_pkg.sv ***
// types of the runtime control bank
`default_nettype none
package rmcr_pkg;
    typedef enum logic [1:0] {
        BLINK_OFF = 2'b00,
        BLINK_SLOW = 2'b01,
        BLINK_RSVD = 2'b10,
        BLINK_ON = 2'b11
    } rmcr_blink_type;
    typedef enum logic [1:0] {
        PWR_S0 = 2'b00,
        PWR_S3 = 2'b01,
        PWR_S5 = 2'b10,
        PWR_NOSUPPLY = 2'b11
    } rmcr_power_type;
endpackage
`default_nettype wire

// *** rmcr_led_if.sv ***
// led blink code carried between the bank and the led driver
`default_nettype none
interface rmcr_led_if;
    rmcr_pkg::rmcr_blink_type blinkCode;
    logic ledLevel;
    modport bank(output blinkCode, input ledLevel);
    modport drive(input blinkCode, output ledLevel);
endinterface
`default_nettype wire

// *** rmcr_led_blink.sv ***
// led level generator from the blink code
`include "rmcr_map.svh"
`default_nettype none
module rmcr_led_blink #(
    parameter int HALF_CYC = `RMCR_HALF_BLINK_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    rmcr_led_if.drive led
);
    logic [26:0] phaseCount;
    logic phase;
    // ======================================
    // half period counter
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            phaseCount <= 27'h0;
            phase <= 1'b1;
        end else if (phaseCount == 27'(HALF_CYC - 1)) begin
            phaseCount <= 27'h0;
            phase <= ~phase;
        end else begin
            phaseCount <= phaseCount + 27'h1;
        end
    end
    // ======================================
    // code decode; reserved code shows off
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            led.ledLevel <= 1'b0;
        end else begin
            case (led.blinkCode)
                rmcr_pkg::BLINK_SLOW: led.ledLevel <= phase;
                rmcr_pkg::BLINK_ON: led.ledLevel <= 1'b1;
                default: led.ledLevel <= 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** rmcr_power_good.sv ***
// power ok output with optional delay
`include "rmcr_map.svh"
`default_nettype none
module rmcr_power_good #(
    parameter int DELAY_CYC = `RMCR_POWER_OK_DELAY_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic delaySel,
    input wire logic supplyGood,
    output logic powerOk
);
    logic [19:0] waitCount;
    // ======================================
    // delay counter restarts on supply loss
    always_ff @(posedge ref_clk) begin
        if (!nrst || !supplyGood) begin
            waitCount <= 20'h0;
            powerOk <= 1'b0;
        end else if (!delaySel) begin
            powerOk <= 1'b1;
        end else if (waitCount == 20'(DELAY_CYC - 1)) begin
            powerOk <= 1'b1;
        end else begin
            waitCount <= waitCount + 20'h1;
        end
    end
endmodule
`default_nettype wire

// *** rmcr_regs_properties.sv ***
// port level checks of the runtime control bank
`include "rmcr_map.svh"
`default_nettype none
module rmcr_regs_properties (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    input wire logic floppyValid,
    input wire logic serialAValid,
    input wire logic serialBValid,
    input wire logic parallelValid,
    input wire logic floppyAccessOn,
    input wire logic serialAAccessOn,
    input wire logic serialBAccessOn,
    input wire logic parallelAccessOn,
    input wire logic write_protect_n,
    input wire logic coreWriteProtect,
    input wire logic supply_good_in,
    input wire logic power_ok_out,
    input wire logic lpcResetN,
    input wire logic [3:0] bufferedResetN,
    input wire logic [7:0] wakeKeyCode,
    input wire logic [5:0] pinSelect
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] disSeen;
    // ====
    // disable image kept from host writes, so the gates are checked in full
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            disSeen <= 8'h00;
        end else if (regWrite && regAddr == 8'h24) begin
            disSeen <= regWrData;
        end
    end
    // ====
    // gating and outputs
    default clocking dclk @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_floppy_gate: assert property (floppyAccessOn == (floppyValid && !disSeen[3]))
        else $error("floppy access without valid");
    a_serial_b_gate: assert property (serialBAccessOn == (serialBValid && !disSeen[5]))
        else $error("serial b access without valid");
    a_serial_a_gate: assert property (serialAAccessOn == (serialAValid && !disSeen[6]))
        else $error("serial a access without valid");
    a_parallel_gate: assert property (parallelAccessOn == (parallelValid && !disSeen[7]))
        else $error("parallel access without valid");
    a_protect_pin: assert property (!write_protect_n |=> coreWriteProtect)
        else $error("pin protect not passed to core");
    a_reset_follow: assert property (!lpcResetN |=> bufferedResetN == 4'h0)
        else $error("buffered reset high while lpc reset low");
    a_supply_gate: assert property (!supply_good_in |=> !power_ok_out)
        else $error("power ok without supply");
    // ====
    // register access
    a_key_write: assert property ((regWrite && regAddr == 8'h26)
        |=> wakeKeyCode == $past(regWrData)) else $error("scan code write lost");
    a_key_read: assert property ((regRead && !regWrite && regAddr == 8'h26)
        |=> ##1 regRdData == $past(wakeKeyCode)) else $error("scan code read wrong");
    a_select_read: assert property ((regRead && !regWrite && regAddr == 8'h28)
        |=> ##1 regRdData == {2'b00, $past(pinSelect, 2)}) else $error("select read wrong");
endmodule
`default_nettype wire

// *** rmcr_host_model.sv ***
// host side model issuing register strobes to the bank
`default_nettype none
module rmcr_host_model (
    input wire logic ref_clk,
    input wire logic [7:0] regRdData,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrite,
    output logic regRead
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // bus cycles, driven on the falling edge
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        regAddr = addr;
        regWrData = data;
        regWrite = 1'b1;
        @(negedge ref_clk);
        regWrite = 1'b0;
        regAddr = ~addr;
        regWrData = ~data;
    endtask
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge ref_clk);
        regAddr = addr;
        regRead = 1'b1;
        @(negedge ref_clk);
        regRead = 1'b0;
        regAddr = ~addr;
        @(negedge ref_clk);
        data = regRdData;
    endtask
endmodule
`default_nettype wire

// *** rmcr_regs_tb.sv ***
// self-checking bench of the runtime control bank
`default_nettype none
module rmcr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PDLY = 4;
    logic ref_clk = 1'b0, nrst = 1'b0, vccResetN = 1'b1, standbyPorN = 1'b0;
    logic serialBFifoWrite = 1'b0, floppyValid = 1'b1, serialAValid = 1'b1;
    logic serialBValid = 1'b1, parallelValid = 1'b1, drive_select_a_n = 1'b1;
    logic drive_select_b_n = 1'b1, forceProtect = 1'b0, write_protect_n = 1'b1;
    logic sleep_s3_n = 1'b1, sleep_s5_n = 1'b1, supply_good_in = 1'b1, lpcResetN = 1'b1;
    logic [7:0] serialBFifoData = 8'h00;
    logic [7:0] regAddr, regWrData, regRdData, wakeKeyCode;
    logic regWrite, regRead, floppyAccessOn, serialAAccessOn, serialBAccessOn;
    logic parallelAccessOn, coreWriteProtect, ledLevel, ledColor, power_ok_out;
    logic [3:0] bufferedResetN;
    logic [5:0] pinSelect;
    int bad_count = 0;
    int cmp_count = 0;
    logic [7:0] disVal [6] = '{8'hff, 8'h08, 8'h20, 8'h40, 8'h80, 8'h00};
    logic [7:0] rstOff [5] = '{8'h23, 8'h24, 8'h26, 8'h27, 8'h28};
    logic [7:0] rstVal [5] = '{8'h00, 8'h00, 8'h00, 8'hf1, 8'h00};
    rmcr_host_model rmcr_host_model_i (.ref_clk, .regRdData, .regAddr, .regWrData,
        .regWrite, .regRead);
    rmcr_regs #(.POWER_OK_DELAY_CYC(PDLY)) rmcr_regs_i (.ref_clk, .nrst, .vccResetN,
        .standbyPorN, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
        .serialBFifoWrite, .serialBFifoData, .floppyValid, .serialAValid, .serialBValid,
        .parallelValid, .floppyAccessOn, .serialAAccessOn, .serialBAccessOn,
        .parallelAccessOn, .drive_select_a_n, .drive_select_b_n, .forceProtect,
        .write_protect_n, .coreWriteProtect, .sleep_s3_n, .sleep_s5_n, .supply_good_in,
        .ledLevel, .ledColor, .wakeKeyCode, .power_ok_out, .lpcResetN, .bufferedResetN,
        .pinSelect);
    always #4 ref_clk = ~ref_clk;
    // ====
    // shared tasks
    task automatic report(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rmcr_host_model_i.wr(a, d);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rmcr_host_model_i.rd(a, d);
        report(d, exp);
    endtask
    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        report(got, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ====
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        print_verdict();
    end
    // ====
    // tests
    initial begin
        logic [7:0] e;
        idle(10);
        nrst = 1'b1;
        standbyPorN = 1'b1;
        foreach (rstOff[i]) chk_rd(rstOff[i], rstVal[i]);
        serialBFifoData = 8'hff;
        serialBFifoWrite = 1'b1;
        idle(1);
        serialBFifoWrite = 1'b0;
        chk_rd(8'h23, 8'hcf);
        wr(8'h23, 8'h00);
        chk_rd(8'h23, 8'hcf);
        foreach (disVal[i]) begin
            wr(8'h24, disVal[i]);
            chk_rd(8'h24, disVal[i] & 8'he9);
            e = {4'h0, ~disVal[i][3], ~disVal[i][6], ~disVal[i][5], ~disVal[i][7]};
            chk_out({4'h0, floppyAccessOn, serialAAccessOn, serialBAccessOn,
                parallelAccessOn}, e);
        end
        {floppyValid, serialAValid, serialBValid, parallelValid} = 4'h0;
        idle(1);
        chk_out({4'h0, floppyAccessOn, serialAAccessOn, serialBAccessOn,
            parallelAccessOn}, 8'h00);
        chk_out({7'h0, coreWriteProtect}, 8'h00);
        write_protect_n = 1'b0;
        idle(2);
        chk_out({7'h0, coreWriteProtect}, 8'h01);
        write_protect_n = 1'b1;
        wr(8'h24, 8'h01);
        idle(2);
        chk_out({7'h0, coreWriteProtect}, 8'h01);
        wr(8'h24, 8'h00);
        {forceProtect, drive_select_a_n, drive_select_b_n} = 3'b101;
        idle(2);
        chk_out({7'h0, coreWriteProtect}, 8'h01);
        {forceProtect, drive_select_a_n, drive_select_b_n} = 3'b110;
        idle(2);
        chk_out({7'h0, coreWriteProtect}, 8'h01);
        {forceProtect, drive_select_a_n, drive_select_b_n} = 3'b010;
        idle(2);
        chk_out({7'h0, coreWriteProtect}, 8'h00);
        {forceProtect, drive_select_a_n, drive_select_b_n} = 3'b011;
        wr(8'h25, 8'h0f);
        chk_rd(8'h25, 8'h0f);
        chk_out({6'h0, ledColor, ledLevel}, 8'h03);
        sleep_s3_n = 1'b0;
        idle(2);
        chk_rd(8'h25, 8'h0d);
        wr(8'h25, 8'h00);
        chk_rd(8'h25, 8'h0d);
        vccResetN = 1'b0;
        idle(1);
        vccResetN = 1'b1;
        chk_rd(8'h25, 8'h05);
        sleep_s3_n = 1'b1;
        idle(2);
        chk_rd(8'h25, 8'h07);
        for (int c = 0; c < 4; c++) begin
            wr(8'h25, 8'h0c | 8'(c));
            chk_rd(8'h25, 8'h0c | 8'(c));
            chk_out({7'h0, ledLevel}, {7'h0, c[0]});
        end
        sleep_s5_n = 1'b0;
        idle(2);
        chk_rd(8'h25, 8'h0c);
        wr(8'h25, 8'h01);
        chk_rd(8'h25, 8'h01);
        sleep_s5_n = 1'b1;
        idle(2);
        chk_rd(8'h25, 8'h03);
        wr(8'h26, 8'h5a);
        chk_out(wakeKeyCode, 8'h5a);
        chk_rd(8'h26, 8'h5a);
        supply_good_in = 1'b0;
        wr(8'h27, 8'hf0);
        chk_out({7'h0, power_ok_out}, 8'h00);
        supply_good_in = 1'b1;
        idle(2);
        chk_out({7'h0, power_ok_out}, 8'h01);
        supply_good_in = 1'b0;
        wr(8'h27, 8'hf1);
        supply_good_in = 1'b1;
        idle(2);
        chk_out({7'h0, power_ok_out}, 8'h00);
        idle(PDLY + 2);
        chk_out({7'h0, power_ok_out}, 8'h01);
        wr(8'h27, 8'hf2);
        wr(8'h27, 8'hf1);
        chk_rd(8'h27, 8'hf2);
        wr(8'h27, 8'hae);
        chk_rd(8'h27, 8'ha2);
        chk_out({4'h0, bufferedResetN}, 8'h06);
        standbyPorN = 1'b0;
        idle(1);
        standbyPorN = 1'b1;
        chk_rd(8'h27, 8'ha1);
        lpcResetN = 1'b0;
        idle(2);
        chk_out({4'h0, bufferedResetN}, 8'h00);
        lpcResetN = 1'b1;
        wr(8'h28, 8'hff);
        chk_out({2'h0, pinSelect}, 8'h3f);
        wr(8'h40, 8'h55);
        chk_rd(8'h40, 8'h00);
        chk_rd(8'h28, 8'h3f);
        print_verdict();
    end
endmodule
bind rmcr_regs rmcr_regs_properties rmcr_regs_properties_i (.ref_clk, .nrst, .regAddr,
    .regWrData, .regWrite, .regRead, .regRdData, .floppyValid, .serialAValid,
    .serialBValid, .parallelValid, .floppyAccessOn, .serialAAccessOn, .serialBAccessOn,
    .parallelAccessOn, .write_protect_n, .coreWriteProtect, .supply_good_in,
    .power_ok_out, .lpcResetN, .bufferedResetN, .wakeKeyCode, .pinSelect);
`default_nettype wire
